// ### logic/bec_pkg.sv
// =============================================================
// band locking encryption control constants
package bec_pkg;
  localparam int BEC_BANDS   = 32;
  localparam int BEC_KEY_W   = 256;
  localparam int BEC_LBA_W   = 32;
  localparam int BEC_WORDS   = 8;
  localparam int BEC_PWD_CNT = 34;
  localparam int BEC_PWD_OWN = 0;
  localparam int BEC_PWD_ERS = 1;
  localparam int BEC_PWD_BND = 2;
  // register byte offsets
  localparam logic [7:0] BEC_OFS_CMD   = 8'h00;
  localparam logic [7:0] BEC_OFS_STAT  = 8'h04;
  localparam logic [7:0] BEC_OFS_START = 8'h08;
  localparam logic [7:0] BEC_OFS_RANGE = 8'h0c;
  localparam logic [7:0] BEC_OFS_BCFG  = 8'h10;
  localparam logic [7:0] BEC_OFS_LOCK  = 8'h14;
  localparam logic [7:0] BEC_OFS_CRED  = 8'h20;
  localparam logic [7:0] BEC_OFS_DATA  = 8'h40;
  // command word fields
  localparam int BEC_CMD_OP  = 0;
  localparam int BEC_CMD_SA  = 8;
  localparam int BEC_CMD_MTH = 16;
  localparam int BEC_CMD_BND = 24;
  localparam logic [7:0] BEC_OP_OUT  = 8'hb5;
  localparam logic [7:0] BEC_OP_IN   = 8'ha2;
  localparam logic [7:0] BEC_OP_SAN  = 8'h48;
  localparam logic [4:0] BEC_SA_CERS = 5'h03;
  // band config bits
  localparam int BEC_CFG_RLE = 0;
  localparam int BEC_CFG_WLE = 1;
  localparam int BEC_CFG_LPC = 2;
  localparam int BEC_CFG_RLK = 3;
  localparam int BEC_CFG_WLK = 4;
  localparam int BEC_CFG_FWL = 5;
  // status bits
  localparam int BEC_ST_BUSY = 0;
  localparam int BEC_ST_DONE = 1;
  localparam int BEC_ST_ERR  = 4;
  localparam logic [31:0] BEC_LFSR_POLY = 32'h8020_0003;
  localparam logic [31:0] BEC_LFSR_SEED = 32'h1357_9bdf;
  typedef enum logic [3:0] {
    BEC_M_SET_OWNER = 4'h0, BEC_M_SET_ERASE = 4'h1,
    BEC_M_SET_BANDP = 4'h2, BEC_M_LOCK_CFG  = 4'h3,
    BEC_M_ENABLE    = 4'h4, BEC_M_SET_RANGE = 4'h5,
    BEC_M_CERASE    = 4'h6, BEC_M_FW_LOCK   = 4'h7,
    BEC_M_REVERT    = 4'h8, BEC_M_RANDOM    = 4'h9,
    BEC_M_READ_FDP  = 4'ha
  } bec_method_t;
  typedef enum logic [2:0] {
    BEC_E_NONE = 3'h0, BEC_E_AUTH = 3'h1, BEC_E_OP = 3'h2,
    BEC_E_ENABLE = 3'h3, BEC_E_OVERLAP = 3'h4, BEC_E_BAND = 3'h5
  } bec_err_t;
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [BEC_LBA_W-1:0] lba;
    logic [31:0]          data;
  } bec_media_req_t;
  typedef struct packed {
    logic        valid;
    logic        refused;
    logic [4:0]  band;
    logic [31:0] data;
  } bec_media_rsp_t;
endpackage : bec_pkg

// ### logic/bec_top.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Behaviour
// - every media word passes the keyed tweak cipher stage; no bypass exists
// - one cipher stage instance per host port
// - keys come from the random source on crypto erase, sanitize or revert; after reset every key is zero; no register path returns a key
// - keys are held wrapped and unwrapped only inside the cipher stage
// - one key per band, chosen by the band owning the LBA
// - security out commands need matching credentials or are rejected; security in and sanitize need none
// - admin methods accept owner or factory default password
// - band methods accept that band's password or the erase master
// - all passwords reset to the factory default, which is readable
// - hardware random source feeds keys and host random reads
// - power cycle locks bands with lock_on_power_cycle and both lock enables
// - locked bands refuse reads or writes until unlocked with credentials
// - at factory state every LBA belongs to band zero
// - host gives start and range for band one; band zero loses it
// - bands two to 31 take no range until enabled by erase master
// - overlapping ranges rejected; adjacent ranges accepted
// - crypto erase overwrites the band key with a fresh random key
// - sanitize 48h action 3 replaces every key
// - firmware accepted only if encrypting, signed, fitting and port unlocked
// - security out B5h and security in A2h are decoded
// - revert with physical revert code erases all bands and restores factory
module bec_top
  import bec_pkg::*;
#(
  parameter int              NUM_PORTS     = 2,
  parameter logic [255:0]    FACTORY_PWD   = {8{32'h5a5a_1234}}, // arbitrary
  parameter logic [255:0]    REVERT_CODE   = {8{32'h0bad_c0de}}, // arbitrary
  parameter logic [255:0]    KEY_WRAP      = {8{32'h3c3c_a5a5}}  // arbitrary
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           power_cycle,
  input  wire bec_media_req_t media_req [NUM_PORTS],
  output bec_media_rsp_t      media_rsp [NUM_PORTS],
  input  wire logic           fw_img_valid,
  input  wire logic           fw_is_encrypting,
  input  wire logic           fw_signed_ok,
  input  wire logic           fw_fit_ok,
  output logic                fw_accept,
  output logic                fw_reject
);

  // =============================================================
  // parameter check
  if (NUM_PORTS < 1) begin : g_chk
    $error("NUM_PORTS must be at least one");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_EXEC = 4'b0010, S_WALK = 4'b0100, S_DONE = 4'b1000
  } bec_state_t;

  // =============================================================
  // storage
  bec_state_t     state_reg;
  logic [31:0]    cmd_reg;
  logic [31:0]    start_reg;
  logic [31:0]    range_reg;
  logic [5:0]     bcfg_reg;
  logic [31:0]    cred_reg [BEC_WORDS];
  logic [31:0]    data_reg [BEC_WORDS];
  logic [255:0]   pwd_reg [BEC_PWD_CNT];
  logic [255:0]   key_wrap_reg [BEC_BANDS];
  logic [31:0]    bstart_reg [BEC_BANDS];
  logic [31:0]    brange_reg [BEC_BANDS];
  logic [31:0]    ben_reg;
  logic [31:0]    rle_reg;
  logic [31:0]    wle_reg;
  logic [31:0]    lpc_reg;
  logic [31:0]    rlk_reg;
  logic [31:0]    wlk_reg;
  logic           fw_open_reg;
  logic           done_reg;
  bec_err_t       err_reg;
  logic [4:0]     walk_reg;
  logic [31:0]    rng_reg [BEC_WORDS];
  logic [255:0]   rng_all;
  logic [255:0]   cred_all;

  // =============================================================
  // decode
  logic           apb_wr;
  logic           apb_rd_ok;
  logic           cmd_go;
  logic [7:0]     op;
  logic [4:0]     sa;
  bec_method_t    mth;
  logic [4:0]     band;
  logic [5:0]     pidx;
  logic           is_owner;
  logic           is_fdp;
  logic           is_erase;
  logic           is_bandm;
  logic           is_revert;
  logic           ok;
  logic           do_walk;
  bec_err_t       err_next;
  logic [32:0]    new_end;
  logic           overlap;

  assign apb_wr = psel & penable & pwrite;
  assign cmd_go = apb_wr & (paddr == BEC_OFS_CMD) & (state_reg == S_IDLE);
  assign op     = cmd_reg[BEC_CMD_OP +: 8];
  assign sa     = cmd_reg[BEC_CMD_SA +: 5];
  assign mth    = bec_method_t'(cmd_reg[BEC_CMD_MTH +: 4]);
  assign band   = cmd_reg[BEC_CMD_BND +: 5];
  assign pidx   = 6'(BEC_PWD_BND) + {1'b0, band};

  // gather credential and random words into 256-bit values
  always_comb begin
    cred_all = '0;
    rng_all  = '0;
    for (int i = 0; i < BEC_WORDS; i++) begin
      cred_all[i*32 +: 32] = cred_reg[i];
      rng_all[i*32 +: 32]  = rng_reg[i];
    end
  end

  // credential matches
  assign is_owner  = cred_all == pwd_reg[BEC_PWD_OWN];
  assign is_fdp    = cred_all == FACTORY_PWD;
  assign is_erase  = cred_all == pwd_reg[BEC_PWD_ERS];
  assign is_bandm  = cred_all == pwd_reg[pidx];
  assign is_revert = cred_all == REVERT_CODE;

  // overlap test of the requested range against other bands
  always_comb begin
    logic [32:0] b_end;
    b_end   = '0;
    new_end = {1'b0, start_reg} + {1'b0, range_reg} - 33'd1;
    overlap = 1'b0;
    for (int b = 1; b < BEC_BANDS; b++) begin
      b_end = {1'b0, bstart_reg[b]} + {1'b0, brange_reg[b]} - 33'd1;
      if (5'(b) != band && brange_reg[b] != '0 && range_reg != '0 &&
          !(new_end < {1'b0, bstart_reg[b]} || b_end < {1'b0, start_reg}))
        overlap = 1'b1;
    end
  end

  // command authorisation and validity
  always_comb begin
    err_next = BEC_E_NONE;
    do_walk  = 1'b0;
    if (op == BEC_OP_SAN && sa == BEC_SA_CERS) begin
      do_walk = 1'b1;
    end else if (op == BEC_OP_OUT) begin
      case (mth)
        BEC_M_SET_OWNER, BEC_M_FW_LOCK: begin
          if (!(is_owner || is_fdp)) err_next = BEC_E_AUTH;
        end
        BEC_M_SET_ERASE, BEC_M_ENABLE: begin
          if (!is_erase) err_next = BEC_E_AUTH;
        end
        BEC_M_SET_BANDP, BEC_M_LOCK_CFG, BEC_M_CERASE: begin
          if (!(is_bandm || is_erase)) err_next = BEC_E_AUTH;
        end
        BEC_M_SET_RANGE: begin
          if (!(is_bandm || is_erase)) err_next = BEC_E_AUTH;
          else if (band == 5'd0) err_next = BEC_E_BAND;
          else if (!ben_reg[band]) err_next = BEC_E_ENABLE;
          else if (new_end[32] || overlap) err_next = BEC_E_OVERLAP;
        end
        BEC_M_REVERT: begin
          if (!is_revert) err_next = BEC_E_AUTH;
          else do_walk = 1'b1;
        end
        default: err_next = BEC_E_OP;
      endcase
    end else if (op == BEC_OP_IN) begin
      if (mth != BEC_M_RANDOM && mth != BEC_M_READ_FDP) err_next = BEC_E_OP;
    end else begin
      err_next = BEC_E_OP;
    end
  end

  assign ok = (state_reg == S_EXEC) && (err_next == BEC_E_NONE);

  // =============================================================
  // command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      walk_reg  <= '0;
      done_reg  <= 1'b0;
      err_reg   <= BEC_E_NONE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (cmd_go) begin
            state_reg <= S_EXEC;
            done_reg  <= 1'b0;
          end
        end
        S_EXEC: begin
          err_reg   <= err_next;
          walk_reg  <= '0;
          state_reg <= (ok && do_walk) ? S_WALK : S_DONE;
        end
        S_WALK: begin
          walk_reg <= walk_reg + 5'd1;
          if (walk_reg == 5'(BEC_BANDS - 1)) state_reg <= S_DONE;
        end
        S_DONE: begin
          done_reg  <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // =============================================================
  // random source: one lfsr lane per word
  for (genvar i = 0; i < BEC_WORDS; i++) begin : g_rng
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rng_reg[i] <= BEC_LFSR_SEED ^ 32'(i * 32'h0101_0101);
      end else begin
        rng_reg[i] <= rng_reg[i][0] ? ((rng_reg[i] >> 1) ^ BEC_LFSR_POLY)
                                    : (rng_reg[i] >> 1);
      end
    end
  end

  // =============================================================
  // wrapped key store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < BEC_BANDS; b++) key_wrap_reg[b] <= KEY_WRAP;
    end else if (state_reg == S_WALK) begin
      key_wrap_reg[walk_reg] <= rng_all ^ KEY_WRAP;
    end else if (ok && op == BEC_OP_OUT && mth == BEC_M_CERASE) begin
      key_wrap_reg[band] <= rng_all ^ KEY_WRAP;
    end
  end

  // =============================================================
  // password store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < BEC_PWD_CNT; p++) pwd_reg[p] <= FACTORY_PWD;
    end else if (ok && op == BEC_OP_OUT) begin
      case (mth)
        BEC_M_SET_OWNER: begin
          for (int i = 0; i < BEC_WORDS; i++)
            pwd_reg[BEC_PWD_OWN][i*32 +: 32] <= data_reg[i];
        end
        BEC_M_SET_ERASE: begin
          for (int i = 0; i < BEC_WORDS; i++)
            pwd_reg[BEC_PWD_ERS][i*32 +: 32] <= data_reg[i];
        end
        BEC_M_SET_BANDP: begin
          for (int i = 0; i < BEC_WORDS; i++)
            pwd_reg[pidx][i*32 +: 32] <= data_reg[i];
        end
        BEC_M_REVERT: begin
          for (int p = 0; p < BEC_PWD_CNT; p++) pwd_reg[p] <= FACTORY_PWD;
        end
        default: ;
      endcase
    end
  end

  // =============================================================
  // band table and lock state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < BEC_BANDS; b++) begin
        bstart_reg[b] <= '0;
        brange_reg[b] <= '0;
      end
      ben_reg     <= 32'h0000_0003;
      fw_open_reg <= 1'b1;
    end else if (ok && op == BEC_OP_OUT) begin
      case (mth)
        BEC_M_SET_RANGE: begin
          bstart_reg[band] <= start_reg;
          brange_reg[band] <= range_reg;
        end
        BEC_M_ENABLE: ben_reg[band] <= 1'b1;
        BEC_M_FW_LOCK: fw_open_reg <= ~bcfg_reg[BEC_CFG_FWL];
        BEC_M_REVERT: begin
          for (int b = 0; b < BEC_BANDS; b++) begin
            bstart_reg[b] <= '0;
            brange_reg[b] <= '0;
          end
          ben_reg     <= 32'h0000_0003;
          fw_open_reg <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // lock settings, power-cycle locking, credentialed unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rle_reg <= '0;
      wle_reg <= '0;
      lpc_reg <= '0;
      rlk_reg <= '0;
      wlk_reg <= '0;
    end else if (ok && op == BEC_OP_OUT && mth == BEC_M_REVERT) begin
      rle_reg <= '0;
      wle_reg <= '0;
      lpc_reg <= '0;
      rlk_reg <= '0;
      wlk_reg <= '0;
    end else begin
      if (ok && op == BEC_OP_OUT && mth == BEC_M_LOCK_CFG) begin
        rle_reg[band] <= bcfg_reg[BEC_CFG_RLE];
        wle_reg[band] <= bcfg_reg[BEC_CFG_WLE];
        lpc_reg[band] <= bcfg_reg[BEC_CFG_LPC];
        rlk_reg[band] <= bcfg_reg[BEC_CFG_RLK];
        wlk_reg[band] <= bcfg_reg[BEC_CFG_WLK];
      end
      if (power_cycle) begin
        for (int b = 0; b < BEC_BANDS; b++) begin
          if (lpc_reg[b] && rle_reg[b] && wle_reg[b]) begin
            rlk_reg[b] <= 1'b1;
            wlk_reg[b] <= 1'b1;
          end
        end
      end
    end
  end

  // =============================================================
  // apb writable registers and data window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg   <= '0;
      start_reg <= '0;
      range_reg <= '0;
      bcfg_reg  <= '0;
      for (int i = 0; i < BEC_WORDS; i++) begin
        cred_reg[i] <= '0;
        data_reg[i] <= '0;
      end
    end else begin
      if (cmd_go) cmd_reg <= pwdata;
      if (apb_wr && paddr == BEC_OFS_START) start_reg <= pwdata;
      if (apb_wr && paddr == BEC_OFS_RANGE) range_reg <= pwdata;
      if (apb_wr && paddr == BEC_OFS_BCFG) bcfg_reg <= pwdata[5:0];
      for (int i = 0; i < BEC_WORDS; i++) begin
        if (apb_wr && paddr == BEC_OFS_CRED + 8'(i * 4)) cred_reg[i] <= pwdata;
        if (apb_wr && paddr == BEC_OFS_DATA + 8'(i * 4)) data_reg[i] <= pwdata;
        if (ok && op == BEC_OP_IN && mth == BEC_M_RANDOM)
          data_reg[i] <= rng_reg[i];
        if (ok && op == BEC_OP_IN && mth == BEC_M_READ_FDP)
          data_reg[i] <= FACTORY_PWD[i*32 +: 32];
      end
    end
  end

  // =============================================================
  // apb read mux; credentials and keys never read back
  always_comb begin
    prdata    = '0;
    apb_rd_ok = 1'b1;
    case (paddr)
      BEC_OFS_CMD:   prdata = cmd_reg;
      BEC_OFS_STAT:  prdata = {25'd0, err_reg, 2'd0, done_reg,
                              state_reg != S_IDLE};
      BEC_OFS_START: prdata = start_reg;
      BEC_OFS_RANGE: prdata = range_reg;
      BEC_OFS_BCFG:  prdata = {26'd0, bcfg_reg};
      BEC_OFS_LOCK:  prdata = rlk_reg | wlk_reg;
      default: begin
        apb_rd_ok = 1'b0;
        for (int i = 0; i < BEC_WORDS; i++) begin
          if (paddr == BEC_OFS_CRED + 8'(i * 4)) apb_rd_ok = 1'b1;
          if (paddr == BEC_OFS_DATA + 8'(i * 4)) begin
            apb_rd_ok = 1'b1;
            prdata    = data_reg[i];
          end
        end
      end
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~apb_rd_ok;

  // =============================================================
  // firmware download gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_accept <= 1'b0;
      fw_reject <= 1'b0;
    end else begin
      fw_accept <= fw_img_valid & fw_is_encrypting & fw_signed_ok &
                   fw_fit_ok & fw_open_reg;
      fw_reject <= fw_img_valid & ~(fw_is_encrypting & fw_signed_ok &
                   fw_fit_ok & fw_open_reg);
    end
  end

  // =============================================================
  // keyed tweak stage: symmetric, so the same mask encrypts and decrypts
  function automatic logic [31:0] cipher_mask(input logic [255:0] key,
                                              input logic [31:0]  lba);
    logic [31:0] m;
    m = lba ^ key[31:0];
    for (int r = 0; r < BEC_WORDS; r++)
      m = {m[26:0], m[31:27]} ^ key[r*32 +: 32] ^ (m + 32'(r));
    return m;
  endfunction : cipher_mask

  // =============================================================
  // per-port band lookup and inline cipher
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [4:0]   hit_band;
    logic         locked;
    logic [255:0] key;

    // owning band from the start and range table
    always_comb begin
      hit_band = 5'd0;
      for (int b = 1; b < BEC_BANDS; b++) begin
        if (brange_reg[b] != '0 && media_req[p].lba >= bstart_reg[b] &&
            (media_req[p].lba - bstart_reg[b]) < brange_reg[b])
          hit_band = 5'(b);
      end
    end

    assign locked = media_req[p].write ? wlk_reg[hit_band]
                                       : rlk_reg[hit_band];
    assign key    = key_wrap_reg[hit_band] ^ KEY_WRAP;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        media_rsp[p] <= '0;
      end else begin
        media_rsp[p].valid   <= media_req[p].valid;
        media_rsp[p].refused <= media_req[p].valid & locked;
        media_rsp[p].band    <= hit_band;
        media_rsp[p].data    <= locked ? 32'h0000_0000 :
          media_req[p].data ^ cipher_mask(key, media_req[p].lba);
      end
    end
  end

endmodule : bec_top

// ### tb/bec_properties.sv
`timescale 1ns/100ps
// =============================================
// port checker for the band control block
module bec_properties
  import bec_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire bec_media_req_t media_req [NUM_PORTS],
  input wire bec_media_rsp_t media_rsp [NUM_PORTS],
  input wire logic           fw_img_valid,
  input wire logic           fw_is_encrypting,
  input wire logic           fw_signed_ok,
  input wire logic           fw_fit_ok,
  input wire logic           fw_accept,
  input wire logic           fw_reject
);
  // one clock domain, reset disables all checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_error_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  media_answer_a: assert property (media_req[0].valid |=> media_rsp[0].valid)
    else $error("port zero answer missing");
  second_port_a: assert property (media_req[1].valid |=> media_rsp[1].valid)
    else $error("port one answer missing");
  answer_cause_a: assert property (media_rsp[0].valid |-> $past(media_req[0].valid))
    else $error("answer without request");
  refused_blank_a: assert property (media_rsp[0].refused |-> media_rsp[0].valid
    && media_rsp[0].data == 32'h0000_0000)
    else $error("refused answer carries data");
  fw_gate_a: assert property (fw_accept |->
    $past(fw_img_valid && fw_is_encrypting && fw_signed_ok && fw_fit_ok))
    else $error("image accepted without all checks");
  fw_plain_a: assert property (fw_img_valid && !fw_is_encrypting |=>
    fw_reject && !fw_accept)
    else $error("plain image not rejected");
  fw_one_answer_a: assert property (fw_img_valid |=> fw_accept != fw_reject)
    else $error("image answer not exactly one pulse");
  fw_quiet_a: assert property (!fw_img_valid |=> !fw_accept && !fw_reject)
    else $error("image answer without request");
endmodule : bec_properties

bind bec_top bec_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .media_req, .media_rsp,
  .fw_img_valid, .fw_is_encrypting, .fw_signed_ok, .fw_fit_ok, .fw_accept, .fw_reject
);

// ### tb/bec_host_model.sv
`timescale 1ns/100ps
// =============================================
// host initiator speaking the register bus
module bec_host_model
  import bec_pkg::*;
(
  input wire logic   pclk,
  input wire logic   pready,
  input wire logic   pslverr,
  input wire logic [31:0] prdata,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  logic last_err;
  // one transfer: setup, access held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) tb_top.hang();
  endtask : xfer
  // credentials go with every security out command, eight words low first
  task automatic cred(input logic [255:0] v);
    logic [31:0] q;
    for (int i = 0; i < 8; i++) xfer(1'b1, BEC_OFS_CRED + 8'(4 * i), v[32*i +: 32], q);
  endtask : cred
endmodule : bec_host_model

// ### tb/tb_top.sv
`timescale 1ns/100ps
// =============================================
// band control bench
module tb_top;
  import bec_pkg::*;
  localparam logic [255:0] FDP = {8{32'h2468_ace1}}; // arbitrary value
  localparam logic [255:0] PRC = {8{32'h7e57_0c0d}}; // arbitrary value
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, power_cycle;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, c, q;
  logic           fw_img_valid, fw_is_encrypting, fw_signed_ok, fw_fit_ok;
  logic           fw_accept, fw_reject;
  bec_media_req_t req [2];
  bec_media_rsp_t rsp [2];
  bec_media_rsp_t r0, r1;
  int             err_count, check_count;
  bec_top #(.NUM_PORTS(2), .FACTORY_PWD(FDP), .REVERT_CODE(PRC)) DUT (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_cycle,
    .media_req(req), .media_rsp(rsp), .fw_img_valid, .fw_is_encrypting,
    .fw_signed_ok, .fw_fit_ok, .fw_accept, .fw_reject);
  bec_host_model host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  // clock at 100 MHz
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic hang();
    err_count++;
    conclude();
  endtask : hang
  function automatic logic [31:0] cw(logic [7:0] op, logic [3:0] m, logic [4:0] b);
    return {3'h0, b, 4'h0, m, 8'h00, op};
  endfunction : cw
  // command then status poll, error field compared
  task automatic cmd(input logic [31:0] w, input logic [2:0] e);
    int n;
    host.xfer(1'b1, BEC_OFS_CMD, w, q);
    n = 0;
    do begin
      host.xfer(1'b0, BEC_OFS_STAT, 32'h0000_0000, q);
      n++;
    end while (!(q[1] && !q[0]) && n < 60);
    if (!(q[1] && !q[0])) hang();
    chk({29'h0, q[6:4]}, {29'h0, e});
  endtask : cmd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  // same word on both ports, answers caught after the taking edge
  task automatic mx(input logic w, input logic [31:0] l, input logic [31:0] d);
    @(posedge pclk);
    foreach (req[i]) req[i] <= '{1'b1, w, l, d};
    @(posedge pclk);
    foreach (req[i]) req[i] <= '0;
    #1 r0 = rsp[0];
    r1 = rsp[1];
  endtask : mx
  task automatic fw(input logic [2:0] b, input logic a);
    @(posedge pclk);
    fw_img_valid <= 1'b1;
    {fw_is_encrypting, fw_signed_ok, fw_fit_ok} <= b;
    @(posedge pclk);
    fw_img_valid <= 1'b0;
    #1 chk({31'h0, fw_accept}, {31'h0, a});
    chk({31'h0, fw_reject}, {31'h0, !a});
  endtask : fw
  // main sequence
  initial begin
    pclk = 0; presetn = 0; power_cycle = 0; err_count = 0; check_count = 0;
    host.psel = 0; host.penable = 0; host.pwrite = 0; host.paddr = 0; host.pwdata = 0;
    fw_img_valid = 0; fw_is_encrypting = 0; fw_signed_ok = 0; fw_fit_ok = 0;
    foreach (req[i]) req[i] = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    mx(1'b1, 32'h0000_0064, 32'hcafe_f00d);
    chk({27'h0, r0.band}, 32'h0000_0000);
    chk({31'h0, r1.valid}, 32'h0000_0001);
    c = r0.data;
    chk({31'h0, c == 32'hcafe_f00d}, 32'h0000_0000);
    mx(1'b0, 32'h0000_0064, c);
    chk(r0.data, 32'hcafe_f00d);
    cmd(cw(BEC_OP_IN, BEC_M_READ_FDP, 5'h00), BEC_E_NONE);
    host.xfer(1'b0, BEC_OFS_DATA, 32'h0000_0000, q);
    chk(q, FDP[31:0]);
    host.cred(FDP);
    wr(BEC_OFS_START, 32'h0000_1000);
    wr(BEC_OFS_RANGE, 32'h0000_1000);
    cmd(cw(BEC_OP_OUT, BEC_M_SET_RANGE, 5'h01), BEC_E_NONE);
    mx(1'b0, 32'h0000_1fff, c);
    chk({27'h0, r0.band}, 32'h0000_0001);
    mx(1'b0, 32'h0000_0fff, c);
    chk({27'h0, r0.band}, 32'h0000_0000);
    cmd(cw(BEC_OP_OUT, BEC_M_SET_RANGE, 5'h02), BEC_E_ENABLE);
    cmd(cw(BEC_OP_OUT, BEC_M_ENABLE, 5'h02), BEC_E_NONE);
    wr(BEC_OFS_START, 32'h0000_1fff);
    cmd(cw(BEC_OP_OUT, BEC_M_SET_RANGE, 5'h02), BEC_E_OVERLAP);
    wr(BEC_OFS_START, 32'h0000_2000);
    cmd(cw(BEC_OP_OUT, BEC_M_SET_RANGE, 5'h02), BEC_E_NONE);
    host.cred('0);
    cmd(cw(BEC_OP_OUT, BEC_M_LOCK_CFG, 5'h01), BEC_E_AUTH);
    host.cred(FDP);
    wr(BEC_OFS_BCFG, 32'h0000_0007);
    cmd(cw(BEC_OP_OUT, BEC_M_LOCK_CFG, 5'h01), BEC_E_NONE);
    @(posedge pclk);
    power_cycle <= 1'b1;
    @(posedge pclk);
    power_cycle <= 1'b0;
    mx(1'b0, 32'h0000_1000, c);
    chk({31'h0, r0.refused}, 32'h0000_0001);
    wr(BEC_OFS_BCFG, 32'h0000_0003);
    cmd(cw(BEC_OP_OUT, BEC_M_LOCK_CFG, 5'h01), BEC_E_NONE);
    mx(1'b0, 32'h0000_1000, c);
    chk({31'h0, r0.refused}, 32'h0000_0000);
    cmd(cw(8'h00, BEC_M_LOCK_CFG, 5'h01), BEC_E_OP);
    for (int i = 0; i < 8; i++) fw(3'(i), i == 7);
    wr(BEC_OFS_BCFG, 32'h0000_0020);
    cmd(cw(BEC_OP_OUT, BEC_M_FW_LOCK, 5'h00), BEC_E_NONE);
    fw(3'h7, 1'b0);
    cmd(32'h0000_0348, BEC_E_NONE);
    mx(1'b0, 32'h0000_0064, c);
    chk({31'h0, r0.data == 32'hcafe_f00d}, 32'h0000_0000);
    cmd(cw(BEC_OP_IN, BEC_M_RANDOM, 5'h00), BEC_E_NONE);
    host.xfer(1'b0, BEC_OFS_DATA, 32'h0000_0000, q);
    chk({31'h0, q == FDP[31:0]}, 32'h0000_0000);
    mx(1'b1, 32'h0000_1000, 32'h1234_5678);
    c = r0.data;
    cmd(cw(BEC_OP_OUT, BEC_M_CERASE, 5'h02), BEC_E_NONE);
    mx(1'b0, 32'h0000_1000, c);
    chk(r0.data, 32'h1234_5678);
    cmd(cw(BEC_OP_OUT, BEC_M_CERASE, 5'h01), BEC_E_NONE);
    mx(1'b0, 32'h0000_1000, c);
    chk({31'h0, r0.data == 32'h1234_5678}, 32'h0000_0000);
    cmd(cw(BEC_OP_OUT, BEC_M_REVERT, 5'h00), BEC_E_AUTH);
    host.cred(PRC);
    cmd(cw(BEC_OP_OUT, BEC_M_REVERT, 5'h00), BEC_E_NONE);
    mx(1'b0, 32'h0000_1000, c);
    chk({27'h0, r0.band}, 32'h0000_0000);
    host.xfer(1'b0, 8'hfc, 32'h0000_0000, q);
    chk({31'h0, host.last_err}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    conclude();
  end
endmodule : tb_top
